// >>> logic/char_display_pkg.sv
// Shared constants for the serial character display port and its driver.
// Assumes a 100 MHz aclk on both ends.
package char_display_pkg;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int LONG_WAIT_US = 1650;
    localparam int SHORT_WAIT_US = 40;
    localparam int LONG_WAIT_CYCLES = LONG_WAIT_US * CLK_MHZ;
    localparam int SHORT_WAIT_CYCLES = SHORT_WAIT_US * CLK_MHZ;
    localparam int SCK_HALF_CYCLES = 8;
    // Byte layout on the serial link
    localparam int NIBBLE_LSB = 0;
    localparam int SPARE_LSB = 4;
    localparam int RSEL_BIT = 6;
    localparam int ENABLE_BIT = 7;
    localparam int XFER_BITS = 8;
    localparam int XFERS_PER_NIBBLE = 3;
    // Display size
    localparam int MAX_CHARS = 80;
    // Commands; only clear and home need the long wait
    localparam logic [7:0] CMD_CLEAR = 8'h01;
    localparam logic [7:0] CMD_HOME = 8'h02;
    localparam logic [7:0] CMD_FUNCTION_2X40 = 8'h3C;
    // Driver register offsets
    localparam logic [3:0] REG_COMMAND = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_PORT = 4'h8;
    localparam logic [7:0] PORT_RESET = 8'h00;
endpackage : char_display_pkg

// >>> logic/char_display_link_if.sv
// Serial link between the display driver and the display port.
// Assumes the bench joins both ends through this interface.
`timescale 1ns/1ps
interface char_display_link_if;
    logic sclk;
    logic mosi;
    logic select_n;
    logic select_routed;
    modport port_end (input sclk, input mosi, input select_n, input select_routed);
    modport driver_end (output sclk, output mosi, output select_n, input select_routed);
endinterface : char_display_link_if

// >>> logic/char_display_port.sv
// Serial-to-parallel port feeding a character display in nibble mode.
// Assumes the link comes from another clock domain; aclk samples all of it.
//
// Summary of operation
// - Shift serial bytes into parallel display lines
// - Bits zero to three drive upper data
// - Bit six drives register select
// - Bit seven drives display enable
// - Bits four, five are unconnected spares
// - Master sends three transfers per write
// - Display is write only, direction low
// - Lower display data lines held zero
// - Act only when select routed and low
// - Supports up to eighty characters, nibble mode
// - Only clock, data and select come in
// - Master waits after each command
// - Master sets two row forty column
`timescale 1ns/1ps
module char_display_port
    import char_display_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    char_display_link_if.port_end link,
    output logic [3:0] display_upper_data_line,
    output logic [3:0] display_lower_data_line,
    output logic register_select_line,
    output logic display_enable,
    output logic display_write_n,
    output logic [1:0] spare_line
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] next_sync1;
    logic [2:0] next_sync2;
    logic sclk_prev;
    logic sel_prev;
    logic next_sclk_prev;
    logic next_sel_prev;
    // Two stages on clock, data and select
    always_comb
    begin
        next_sync1 = {link.sclk, link.mosi, link.select_n | ~link.select_routed};
        next_sync2 = sync1;
        next_sclk_prev = sync2[2];
        next_sel_prev = sync2[0];
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sclk_prev <= 1'b1;
            sel_prev <= 1'b1;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sclk_prev <= next_sclk_prev;
            sel_prev <= next_sel_prev;
        end
    end
    // ----------------------------------------
    // Shift register and output latch
    // ----------------------------------------
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [7:0] held;
    logic [7:0] next_held;
    logic [3:0] count;
    logic [3:0] next_count;
    logic sclk_rise;
    logic sel_active;
    logic sel_release;
    assign sclk_rise = sync2[2] & ~sclk_prev;
    assign sel_active = ~sync2[0];
    assign sel_release = sync2[0] & ~sel_prev;
    // Sample on rising clock, MSB first; latch whole byte at release
    always_comb
    begin
        next_shift = shift;
        next_count = count;
        next_held = held;
        if (sel_active && sclk_rise)
        begin
            next_shift = {shift[6:0], sync2[1]};
            if (count <= 4'(XFER_BITS)) // Saturates past a byte so long frames are dropped
            begin
                next_count = count + 4'h1;
            end
        end
        if (sel_release)
        begin
            if (count == 4'(XFER_BITS))
            begin
                next_held = shift;
            end
            next_count = 4'h0;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shift <= 8'h00;
            held <= 8'h00;
            count <= 4'h0;
        end
        else
        begin
            shift <= next_shift;
            held <= next_held;
            count <= next_count;
        end
    end
    // ----------------------------------------
    // Display pins
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            display_upper_data_line <= 4'h0;
            display_lower_data_line <= 4'h0;
            register_select_line <= 1'b0;
            display_enable <= 1'b0;
            display_write_n <= 1'b0;
            spare_line <= 2'h0;
        end
        else
        begin
            display_upper_data_line <= next_held[NIBBLE_LSB +: 4];
            display_lower_data_line <= 4'h0;
            register_select_line <= next_held[RSEL_BIT];
            display_enable <= next_held[ENABLE_BIT];
            display_write_n <= 1'b0;
            spare_line <= next_held[SPARE_LSB +: 2];
        end
    end
endmodule : char_display_port

// >>> logic/char_display_driver.sv
// Serial master that turns display bytes into three-transfer nibble writes.
// Assumes software on AXI4-Lite and a port at the far end of the link.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module char_display_driver
    import char_display_pkg::*;
#(
    parameter int LONG_WAIT = LONG_WAIT_CYCLES,
    parameter int SHORT_WAIT = SHORT_WAIT_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    char_display_link_if.driver_end link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Wait counts must fit the 20-bit timer
    if (LONG_WAIT < 1 || SHORT_WAIT < 1 || LONG_WAIT >= (1 << 20) || SHORT_WAIT >= (1 << 20))
    begin : g_wait_check
        $error("wait counts out of range");
    end
    typedef enum logic [3:0] {
        IDLE = 4'b0001,
        SHIFT = 4'b0010,
        GAP = 4'b0100,
        WAIT = 4'b1000
    } drv_state_t;
    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    drv_state_t state;
    drv_state_t next_state;
    logic [7:0] byte_q;
    logic [7:0] next_byte_q;
    logic rsel;
    logic next_rsel;
    logic half;
    logic next_half;
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic [2:0] bitn;
    logic [2:0] next_bitn;
    logic [19:0] timer;
    logic [19:0] next_timer;
    logic [7:0] frame;
    logic [7:0] next_frame;
    logic sclk_q;
    logic next_sclk_q;
    logic mosi_q;
    logic next_mosi_q;
    logic sel_q;
    logic next_sel_q;
    logic [7:0] raw_q;
    logic [7:0] next_raw_q;
    logic start;
    logic start_raw;
    logic [8:0] cmd_data;
    logic busy;
    assign busy = (state != IDLE);
    assign link.sclk = sclk_q;
    assign link.mosi = mosi_q;
    assign link.select_n = sel_q;
    // Build one transfer: nibble, select, enable on middle transfer only
    function automatic logic [7:0] make_frame(input logic [3:0] nib, input logic rs,
                                              input logic en);
        make_frame = {en, rs, 2'b00, nib};
    endfunction : make_frame
    // Next-state logic of the nibble sequencer
    always_comb
    begin
        next_state = state;
        next_byte_q = byte_q;
        next_rsel = rsel;
        next_half = half;
        next_phase = phase;
        next_bitn = bitn;
        next_timer = timer;
        next_frame = frame;
        next_sclk_q = sclk_q;
        next_mosi_q = mosi_q;
        next_sel_q = sel_q;
        case (state)
            IDLE:
            begin
                next_sclk_q = 1'b0;
                next_sel_q = 1'b1;
                if (start)
                begin
                    next_byte_q = cmd_data[7:0];
                    next_rsel = cmd_data[8];
                    next_half = start_raw; // Raw byte: one transfer, then the wait
                    next_phase = start_raw ? 2'd2 : 2'd0;
                    next_bitn = 3'd7;
                    next_timer = 20'(SCK_HALF_CYCLES);
                    next_frame = start_raw ? cmd_data[7:0]
                        : make_frame(cmd_data[7:4], cmd_data[8], 1'b0);
                    next_sel_q = 1'b0;
                    next_mosi_q = next_frame[7];
                    next_state = SHIFT;
                end
            end
            SHIFT:
            begin
                if (timer > 20'd1)
                begin
                    next_timer = timer - 20'd1;
                end
                else
                begin
                    next_timer = 20'(SCK_HALF_CYCLES);
                    next_sclk_q = ~sclk_q;
                    if (sclk_q)
                    begin
                        if (bitn == 3'd0)
                        begin
                            next_state = GAP;
                            next_sel_q = 1'b1;
                        end
                        else
                        begin
                            next_bitn = bitn - 3'd1;
                            next_mosi_q = frame[bitn - 3'd1];
                        end
                    end
                end
            end
            GAP:
            begin
                if (timer > 20'd1)
                begin
                    next_timer = timer - 20'd1;
                end
                else if (phase < 2'(XFERS_PER_NIBBLE - 1))
                begin
                    next_phase = phase + 2'd1;
                    next_frame = {phase == 2'd0, frame[6:0]};
                    next_bitn = 3'd7;
                    next_timer = 20'(SCK_HALF_CYCLES);
                    next_sel_q = 1'b0;
                    next_mosi_q = next_frame[7];
                    next_state = SHIFT;
                end
                else if (!half)
                begin
                    next_half = 1'b1;
                    next_phase = 2'd0;
                    next_frame = make_frame(byte_q[3:0], rsel, 1'b0);
                    next_bitn = 3'd7;
                    next_timer = 20'(SCK_HALF_CYCLES);
                    next_sel_q = 1'b0;
                    next_mosi_q = next_frame[7];
                    next_state = SHIFT;
                end
                else
                begin
                    next_timer = (!rsel && (byte_q == CMD_CLEAR || byte_q == CMD_HOME))
                        ? 20'(LONG_WAIT) : 20'(SHORT_WAIT);
                    next_state = WAIT;
                end
            end
            WAIT:
            begin
                if (timer > 20'd1)
                begin
                    next_timer = timer - 20'd1;
                end
                else
                begin
                    next_state = IDLE;
                end
            end
            default:
            begin
                next_state = IDLE;
            end
        endcase
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= IDLE;
            byte_q <= 8'h00;
            rsel <= 1'b0;
            half <= 1'b0;
            phase <= 2'd0;
            bitn <= 3'd7;
            timer <= 20'h0_0000;
            frame <= 8'h00;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            sel_q <= 1'b1;
        end
        else
        begin
            state <= next_state;
            byte_q <= next_byte_q;
            rsel <= next_rsel;
            half <= next_half;
            phase <= next_phase;
            bitn <= next_bitn;
            timer <= next_timer;
            frame <= next_frame;
            sclk_q <= next_sclk_q;
            mosi_q <= next_mosi_q;
            sel_q <= next_sel_q;
        end
    end
    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic aw_hold;
    logic next_aw_hold;
    logic [3:0] aw_addr;
    logic [3:0] next_aw_addr;
    logic w_hold;
    logic next_w_hold;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic do_write;
    assign do_write = aw_hold && w_hold && !s_axi_bvalid;
    assign start = do_write && !busy && s_axi_wstrb != 4'h0
        && (aw_addr == REG_COMMAND || aw_addr == REG_PORT);
    assign start_raw = (aw_addr == REG_PORT);
    assign cmd_data = w_data[8:0];
    // Capture address and data separately, answer when both held
    always_comb
    begin
        next_aw_hold = aw_hold;
        next_aw_addr = aw_addr;
        next_w_hold = w_hold;
        next_w_data = w_data;
        next_awready = 1'b0;
        next_wready = 1'b0;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_raw_q = raw_q;
        next_arready = 1'b0;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && !aw_hold && !s_axi_awready)
        begin
            next_awready = 1'b1;
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold && !s_axi_wready)
        begin
            next_wready = 1'b1;
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
        end
        if (do_write)
        begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = 2'b00;
            if (aw_addr == REG_PORT && !busy)
            begin
                next_raw_q = w_data[7:0];
            end
            else if (aw_addr == REG_PORT || (aw_addr == REG_COMMAND && busy))
            begin
                next_bresp = 2'b10;
            end
            else if (aw_addr != REG_COMMAND)
            begin
                next_bresp = 2'b10;
            end
        end
        if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
        begin
            next_arready = 1'b1;
            next_rvalid = 1'b1;
            next_rresp = 2'b00;
            case (s_axi_araddr)
                REG_COMMAND: next_rdata = {23'h0, rsel, byte_q};
                REG_STATUS: next_rdata = {28'h0, state};
                REG_PORT: next_rdata = {24'h0, raw_q};
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = 2'b10;
                end
            endcase
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            aw_addr <= 4'h0;
            w_hold <= 1'b0;
            w_data <= 32'h0000_0000;
            raw_q <= PORT_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end
        else
        begin
            aw_hold <= next_aw_hold;
            aw_addr <= next_aw_addr;
            w_hold <= next_w_hold;
            w_data <= next_w_data;
            raw_q <= next_raw_q;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule : char_display_driver

// >>> verif/char_display_assertions.sv
// Checker for the first link and the display pins of its port.
// Assumes the bench wires it beside the link joining driver and port.
`timescale 1ns/1ps
module char_display_assertions
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic select_n,
    input wire logic select_routed,
    input wire logic [3:0] display_upper_data_line,
    input wire logic [3:0] display_lower_data_line,
    input wire logic register_select_line,
    input wire logic display_enable,
    input wire logic display_write_n,
    input wire logic [1:0] spare_line
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] pins;
    // Byte as the display sees it
    assign pins = {display_enable, register_select_line, spare_line, display_upper_data_line};

    property p_lower_zero;
        display_lower_data_line == 4'h0;
    endproperty
    a_lower_zero: assert property (p_lower_zero) else $error("lower lines driven");
    property p_write_only;
        display_write_n == 1'b0;
    endproperty
    a_write_only: assert property (p_write_only) else $error("direction not low");
    property p_idle;
        select_n |-> !sclk;
    endproperty
    a_idle: assert property (p_idle) else $error("serial clock not idle");
    property p_hold;
        !select_n [*6] |-> $stable(pins);
    endproperty
    a_hold: assert property (p_hold) else $error("pins moved in frame");
    property p_update;
        $changed(pins) |-> $past(select_n, 3) && !$past(select_n, 9);
    endproperty
    a_update: assert property (p_update) else $error("pins moved off release");
    property p_enable_len;
        $rose(display_enable) |-> display_enable [*8] ##[1:400] !display_enable;
    endproperty
    a_enable_len: assert property (p_enable_len) else $error("enable pulse length");
    property p_enable_data;
        display_enable && $past(display_enable) |-> $stable(pins[6:0]);
    endproperty
    a_enable_data: assert property (p_enable_data) else $error("data moved with enable");
    property p_routed;
        !select_routed [*8] |-> $stable(pins);
    endproperty
    a_routed: assert property (p_routed) else $error("pins moved unrouted");
endmodule : char_display_assertions

// >>> verif/tb.sv
// Bench: driver and port on one link, a second port on a bench-driven link.
// Assumes short wait parameters on the driver and a 100 MHz aclk.
`timescale 1ns/1ps
module tb;
    import char_display_pkg::*;
    localparam int LONG_W = 1000;
    localparam int SHORT_W = 100;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] awaddr, wstrb, araddr, up_a, lo_a, up_b, lo_b;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, sp_a, sp_b;
    logic rs_a, en_a, wn_a, rs_b, en_b, wn_b;
    logic [7:0] last_a;
    logic [7:0] seen[$];
    int miscompares;
    int checked;
    char_display_link_if link_a();
    char_display_link_if link_b();
    char_display_driver #(.LONG_WAIT(LONG_W), .SHORT_WAIT(SHORT_W)) char_display_driver_i (
        .aclk(aclk), .aresetn(aresetn), .link(link_a.driver_end),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    char_display_port char_display_port_i (.aclk(aclk), .aresetn(aresetn),
        .link(link_a.port_end), .display_upper_data_line(up_a), .display_lower_data_line(lo_a),
        .register_select_line(rs_a), .display_enable(en_a), .display_write_n(wn_a),
        .spare_line(sp_a));
    char_display_port char_display_port_b_i (.aclk(aclk), .aresetn(aresetn),
        .link(link_b.port_end), .display_upper_data_line(up_b), .display_lower_data_line(lo_b),
        .register_select_line(rs_b), .display_enable(en_b), .display_write_n(wn_b),
        .spare_line(sp_b));
    char_display_assertions char_display_assertions_i (.aclk(aclk), .aresetn(aresetn),
        .sclk(link_a.sclk), .mosi(link_a.mosi), .select_n(link_a.select_n),
        .select_routed(link_a.select_routed), .display_upper_data_line(up_a),
        .display_lower_data_line(lo_a), .register_select_line(rs_a), .display_enable(en_a),
        .display_write_n(wn_a), .spare_line(sp_a));

    // Clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Log each new byte on the first port
    always @(posedge aclk)
    begin
        if (aresetn === 1'b1 && {en_a, rs_a, sp_a, up_a} !== last_a)
        begin
            last_a = {en_a, rs_a, sp_a, up_a};
            seen.push_back(last_a);
        end
    end

    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic hang(input string name);
        chk(name, 32'h0000_0001, 32'h0000_0000);
        give_verdict();
    endtask : hang

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] exp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (200)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                bready <= 1'b0;
                chk("write response", exp, bresp);
                return;
            end
        end
        hang("write response");
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (200)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                rready <= 1'b0;
                d = rdata;
                r = rresp;
                return;
            end
        end
        hang("read response");
    endtask : axi_read

    task automatic read_chk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk("read data", ed, d);
        chk("read response", er, r);
    endtask : read_chk

    task automatic wait_idle(output int cyc);
        logic [31:0] d;
        logic [1:0] r;
        realtime t0;
        t0 = $realtime;
        repeat (1500)
        begin
            axi_read(REG_STATUS, d, r);
            cyc = int'(($realtime - t0) / 10.0);
            if (d === 32'h0000_0001)
                return;
        end
        hang("idle");
    endtask : wait_idle

    // One display byte as two nibbles of three transfers each
    task automatic sc_byte(input logic [7:0] b, input logic rs, output int cyc);
        int k;
        seen.delete();
        axi_write(REG_COMMAND, {23'h0, rs, b}, 4'hF, 2'b00);
        wait_idle(cyc);
        chk("transfer count", 6, 32'(seen.size()));
        for (k = 0; k < 6 && k < seen.size(); k++)
            chk("display byte", {k % 3 == 1, rs, 2'b00, k < 3 ? b[7:4] : b[3:0]}, seen[k]);
    endtask : sc_byte

    // Long wait after clear and home, short otherwise
    task automatic sc_waits;
        int c_fn, c_cl, c_hm;
        sc_byte(CMD_FUNCTION_2X40, 1'b0, c_fn);
        sc_byte(CMD_CLEAR, 1'b0, c_cl);
        sc_byte(CMD_HOME, 1'b0, c_hm);
        chk("clear wait", 1, (c_cl - c_fn) > LONG_W - SHORT_W - 20);
        chk("home wait", 1, (c_hm - c_fn) > LONG_W - SHORT_W - 20);
        chk("clear wait max", 1, (c_cl - c_fn) < LONG_W - SHORT_W + 20);
    endtask : sc_waits

    // Character data, readback, refusals while busy and unmapped places
    task automatic sc_regs;
        int c;
        sc_byte(8'h41, 1'b1, c);
        read_chk(REG_COMMAND, 32'h0000_0141, 2'b00);
        seen.delete();
        axi_write(REG_COMMAND, 32'h0000_0080, 4'hF, 2'b00);
        axi_write(REG_COMMAND, 32'h0000_0055, 4'hF, 2'b10);
        axi_write(REG_PORT, 32'h0000_0011, 4'hF, 2'b10);
        wait_idle(c);
        chk("busy refused", 32'h0888_0000, {seen[0], seen[1], seen[3], seen[5]});
        axi_write(4'hC, 32'h0000_0001, 4'hF, 2'b10);
        read_chk(4'hC, 32'h0000_0000, 2'b10);
        seen.delete();
        axi_write(REG_COMMAND, 32'h0000_0001, 4'h0, 2'b00);
        wait_idle(c);
        chk("no strobe", 0, 32'(seen.size()));
    endtask : sc_regs

    // Raw byte with spares, then ignored while select is not routed
    task automatic sc_raw;
        int c;
        axi_write(REG_PORT, 32'h0000_0065, 4'hF, 2'b00);
        wait_idle(c);
        chk("raw pins", 8'h65, {en_a, rs_a, sp_a, up_a});
        read_chk(REG_PORT, 32'h0000_0065, 2'b00);
        link_a.select_routed <= 1'b0;
        axi_write(REG_PORT, 32'h0000_002A, 4'hF, 2'b00);
        wait_idle(c);
        chk("unrouted pins", 8'h65, {en_a, rs_a, sp_a, up_a});
        link_a.select_routed <= 1'b1;
    endtask : sc_raw

    // Bench frame on the second link, mode 0, most significant bit first
    task automatic bang(input logic [7:0] b, input int bits, input logic [7:0] exp);
        int i;
        @(posedge aclk);
        link_b.select_n <= 1'b0;
        for (i = 7; i > 7 - bits; i--)
        begin
            link_b.mosi <= b[i];
            repeat (8) @(posedge aclk);
            link_b.sclk <= 1'b1;
            repeat (8) @(posedge aclk);
            link_b.sclk <= 1'b0;
        end
        repeat (8) @(posedge aclk);
        link_b.select_n <= 1'b1;
        link_b.mosi <= ~b[8 - bits];
        repeat (16) @(posedge aclk);
        chk("bench port pins", exp, {en_b, rs_b, sp_b, up_b});
        chk("bench port fixed", 5'h00, {lo_b, wn_b});
    endtask : bang

    task automatic sc_link;
        bang(8'hC6, 8, 8'hC6);
        bang(8'hFF, 7, 8'hC6);
        link_b.select_routed <= 1'b0;
        bang(8'h39, 8, 8'hC6);
        link_b.select_routed <= 1'b1;
        bang(8'h39, 8, 8'h39);
    endtask : sc_link

    // Main sequence
    initial
    begin
        miscompares = 0;
        checked = 0;
        last_a = 8'h00;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wstrb, wdata} = 44'h000_0000_0000;
        link_a.select_routed = 1'b1;
        link_b.select_routed = 1'b1;
        link_b.sclk = 1'b0;
        link_b.mosi = 1'b0;
        link_b.select_n = 1'b1;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        read_chk(REG_STATUS, 32'h0000_0001, 2'b00);
        sc_waits();
        sc_regs();
        sc_raw();
        sc_link();
        give_verdict();
    end
endmodule : tb
